// [src/cwg_pkg.sv]
package cwg_pkg;
   // register word offsets (byte addresses)
   localparam logic [7:0] off_shutdown_source_enable = 8'h00;
   localparam logic [7:0] off_rising_deadband_count = 8'h04;
   localparam logic [7:0] off_falling_deadband_count = 8'h08;
   localparam logic [7:0] off_waveform_clock_select = 8'h0c;
   localparam logic [7:0] off_shutdown_control = 8'h10;
   localparam logic [7:0] off_irq_status = 8'h14;
   localparam logic [7:0] off_irq_clear = 8'h18;
   localparam logic [7:0] off_irq_enable = 8'h1c;
   // field positions of shutdown_control
   localparam int shutdown_bit = 7;
   localparam int restart_bit = 6;
   localparam int level_bd_lsb = 4;
   localparam int level_ac_lsb = 2;
   // widths and reset values
   localparam int source_count = 5;
   localparam int delay_width = 6;
   localparam logic [4:0] source_enable_reset = 5'h00;
   localparam logic [5:0] delay_reset = 6'h00;
   localparam logic [5:0] ctrl_reset = 6'h00;
   // shutdown level codes
   localparam logic [1:0] level_inactive = 2'h0;
   localparam logic [1:0] level_float = 2'h1;
   localparam logic [1:0] level_low = 2'h2;
   localparam logic [1:0] level_high = 2'h3;
   // interrupt status bits
   localparam int irq_shutdown_bit = 0;
   localparam int irq_restart_bit = 1;
   localparam int irq_width = 2;

   typedef struct packed {
      logic [4:0] source_enable;
      logic [5:0] rise_count;
      logic [5:0] fall_count;
      logic clock_select;
      logic restart_enable;
      logic [1:0] pair_bd_shutdown_level;
      logic [1:0] pair_ac_shutdown_level;
      logic [1:0] irq_status;
      logic [1:0] irq_enable;
   } regs_t;

   typedef struct packed {
      logic logic_cell_four_output;
      logic logic_cell_two_output;
      logic comparator_two_output;
      logic comparator_one_output;
      logic remappable_shutdown_pin;
   } sources_t;

   typedef struct packed {
      logic [1:0] value;
      logic [1:0] enable;
   } pair_out_t;
endpackage

// [src/deadband_delay.sv]
`timescale 1ns/1ps
// delays one edge direction of a level by count to count+1 generator clock periods
module deadband_delay
   import cwg_pkg::*;
#(
   parameter int width = 6,
   parameter bit rising = 1'b1
)
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic tick,
   // data
   input wire logic data_in,
   input wire logic [width-1:0] count,
   output logic data_out
);
   typedef struct packed {
      logic out;
      logic busy;
      logic [width-1:0] left;
   } state_t;

   state_t cur;
   state_t next_cur;
   logic edge_here;

   assign edge_here = rising ? (data_in && !cur.out) : (!data_in && cur.out);
   assign data_out = cur.out;

   always_comb
   begin
      next_cur = cur;
      if (data_in == cur.out)
      begin
         next_cur.busy = 1'b0;
      end
      else if (count == '0)
      begin
         next_cur.out = data_in;
      end
      else if (!edge_here)
      begin
         next_cur.out = data_in;
      end
      else if (!cur.busy)
      begin
         next_cur.busy = 1'b1;
         next_cur.left = count;
      end
      else if (tick)
      begin
         // count+1 ticks: a partial first period plus count whole ones
         if (cur.left == '0) // [R4] [R5]
         begin
            next_cur.out = data_in;
            next_cur.busy = 1'b0;
         end
         else
         begin
            next_cur.left = cur.left - width'(1);
         end
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         cur <= '0;
      end
      else
      begin
         cur <= next_cur;
      end
   end
endmodule

// [src/cwg_shutdown_deadband.sv]
// Design decisions made here: the APB slave port and the register offsets.
`timescale 1ns/1ps
//
// Contract
// (R1) Enable bits 4 and 3 admit logic cell four and two shutdown sources.
// (R2) Enable bits 2 and 1 admit comparator two and one shutdown sources.
// (R3) Enable bit 0 admits the remappable shutdown pin.
// (R4) Rising count N delays rising edges N to N+1 generator clocks.
// (R5) Falling count N delays falling edges N to N+1 generator clocks.
// (R6) Count zero bypasses the delay entirely.
// (R7) Unimplemented upper bits ignore writes and read zero.
// (R8) All implemented bits reset to zero.
// (R9) Shutdown bit reads one while shutdown active; software may set it.
// (R10) During shutdown each pair takes its 2-bit level field.
// (R11) After shutdown clears, outputs hold until next data rising edge.
// (R12) Clock select picks system clock or fast internal oscillator.
// (R13) Any enabled active source starts shutdown; disabled ones masked.
module cwg_shutdown_deadband
   import cwg_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // generator clock enables
   input wire logic system_tick,
   input wire logic internal_fast_oscillator,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // waveform and sources
   input wire logic data_in,
   input wire sources_t sources,
   // outputs to gate drivers
   output pair_out_t pair_ac,
   output pair_out_t pair_bd,
   output logic shutdown_active,
   output logic irq
);
   typedef struct packed {
      regs_t r;
      logic shutdown;
      logic hold;
      logic prev_data;
      logic [31:0] rdata;
      logic err;
      pair_out_t ac;
      pair_out_t bd;
   } state_t;

   state_t cur;
   state_t next_cur;
   logic tick;
   logic dly_rise;
   logic dly_both;
   logic trip;
   logic wr;
   logic rd;
   logic [4:0] enabled_sources;

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == off_shutdown_source_enable) || (a == off_rising_deadband_count) ||
         (a == off_falling_deadband_count) || (a == off_waveform_clock_select) ||
         (a == off_shutdown_control) || (a == off_irq_status) ||
         (a == off_irq_clear) || (a == off_irq_enable);
   endfunction

   function automatic pair_out_t drive(input logic [1:0] level, input logic run,
                                       input logic active_value);
      pair_out_t p;
      p = '0;
      case (level)
         level_high: p = {2'b11, 2'b11};
         level_low: p = {2'b00, 2'b11};
         level_float: p = {2'b00, 2'b00};
         level_inactive: p = {1'b0, 1'b1, 2'b11};
         default: p = '0;
      endcase
      if (run)
      begin
         p = {active_value, !active_value, 2'b11};
      end
      return p;
   endfunction

   // generator clock: system tick or fast oscillator enable
   assign tick = cur.r.clock_select ? internal_fast_oscillator : system_tick; // [R12]

   // rising delay applies first, then falling delay on the result
   deadband_delay #(.width(delay_width), .rising(1'b1)) rise_dly (
      .ref_clk(ref_clk),
      .rst(rst),
      .tick(tick),
      .data_in(data_in),
      .count(cur.r.rise_count), // [R4] [R6]
      .data_out(dly_rise)
   );

   deadband_delay #(.width(delay_width), .rising(1'b0)) fall_dly (
      .ref_clk(ref_clk),
      .rst(rst),
      .tick(tick),
      .data_in(dly_rise),
      .count(cur.r.fall_count), // [R5] [R6]
      .data_out(dly_both)
   );

   assign enabled_sources = sources & cur.r.source_enable; // [R1] [R2] [R3]
   assign trip = |enabled_sources; // [R13]
   assign wr = psel && penable && pwrite;
   assign rd = psel && !penable && !pwrite;

   always_comb
   begin
      next_cur = cur;
      next_cur.prev_data = data_in;
      next_cur.err = 1'b0;
      if (rd)
      begin
         next_cur.rdata = '0; // [R7]
         case (paddr)
            off_shutdown_source_enable: next_cur.rdata[4:0] = cur.r.source_enable;
            off_rising_deadband_count: next_cur.rdata[5:0] = cur.r.rise_count;
            off_falling_deadband_count: next_cur.rdata[5:0] = cur.r.fall_count;
            off_waveform_clock_select: next_cur.rdata[0] = cur.r.clock_select;
            off_shutdown_control:
            begin
               next_cur.rdata[shutdown_bit] = cur.shutdown; // [R9]
               next_cur.rdata[restart_bit] = cur.r.restart_enable;
               next_cur.rdata[level_bd_lsb +: 2] = cur.r.pair_bd_shutdown_level;
               next_cur.rdata[level_ac_lsb +: 2] = cur.r.pair_ac_shutdown_level;
            end
            off_irq_status: next_cur.rdata[irq_width-1:0] = cur.r.irq_status;
            off_irq_enable: next_cur.rdata[irq_width-1:0] = cur.r.irq_enable;
            default: next_cur.rdata = '0;
         endcase
      end
      if (psel && !penable)
      begin
         next_cur.err = !mapped(paddr);
      end
      if (wr)
      begin
         case (paddr)
            off_shutdown_source_enable: next_cur.r.source_enable = pwdata[4:0]; // [R7]
            off_rising_deadband_count: next_cur.r.rise_count = pwdata[5:0];
            off_falling_deadband_count: next_cur.r.fall_count = pwdata[5:0];
            off_waveform_clock_select: next_cur.r.clock_select = pwdata[0];
            off_shutdown_control:
            begin
               next_cur.shutdown = pwdata[shutdown_bit]; // [R9]
               next_cur.r.restart_enable = pwdata[restart_bit];
               next_cur.r.pair_bd_shutdown_level = pwdata[level_bd_lsb +: 2];
               next_cur.r.pair_ac_shutdown_level = pwdata[level_ac_lsb +: 2];
            end
            off_irq_clear:
               next_cur.r.irq_status = cur.r.irq_status & ~pwdata[irq_width-1:0];
            off_irq_enable: next_cur.r.irq_enable = pwdata[irq_width-1:0];
            default: next_cur.r.irq_status = next_cur.r.irq_status;
         endcase
      end
      // auto-restart clears shutdown once all enabled sources are quiet
      if (cur.shutdown && cur.r.restart_enable && !trip)
      begin
         next_cur.shutdown = 1'b0;
         next_cur.r.irq_status[irq_restart_bit] = 1'b1;
      end
      // trip wins over any clear in the same cycle
      if (trip)
      begin
         next_cur.shutdown = 1'b1; // [R13]
      end
      if (next_cur.shutdown && !cur.shutdown)
      begin
         next_cur.r.irq_status[irq_shutdown_bit] = 1'b1;
      end
      // outputs hold shutdown levels until a data rising edge after release
      if (next_cur.shutdown)
      begin
         next_cur.hold = 1'b1;
      end
      else if (cur.hold && data_in && !cur.prev_data)
      begin
         next_cur.hold = 1'b0; // [R11]
      end
      next_cur.ac = drive(cur.r.pair_ac_shutdown_level, !cur.hold, dly_both); // [R10]
      next_cur.bd = drive(cur.r.pair_bd_shutdown_level, !cur.hold, !dly_both); // [R10]
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         cur <= '0; // [R8]
      end
      else
      begin
         cur <= next_cur;
      end
   end

   assign prdata = cur.rdata;
   assign pready = psel && penable;
   assign pslverr = psel && penable && cur.err;
   assign pair_ac = cur.ac;
   assign pair_bd = cur.bd;
   assign shutdown_active = cur.shutdown;
   assign irq = |(cur.r.irq_status & cur.r.irq_enable);
endmodule

// [tb/cwg_assertions.sv]
`timescale 1ns/1ps
module cwg_checker
   import cwg_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // shutdown
   input wire sources_t sources,
   input wire pair_out_t pair_ac,
   input wire pair_out_t pair_bd,
   input wire logic shutdown_active,
   input wire logic irq
);
   logic [4:0] en;
   logic [3:0] lvl;
   logic wr;
   logic trip;
   assign wr = psel && penable && pwrite;
   assign trip = |(sources & en);
   // shadow of the enables and shutdown levels
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         en <= 5'h00;
         lvl <= 4'h0;
      end
      else if (wr && paddr == off_shutdown_source_enable)
         en <= pwdata[4:0];
      else if (wr && paddr == off_shutdown_control)
         lvl <= pwdata[5:2];
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   sequence held_down;
      shutdown_active && $past(shutdown_active) && $stable(lvl);
   endsequence
   chk_masked_quiet: assert property (!trip && !shutdown_active && !wr |=> !shutdown_active)
      else $error("shutdown without enabled source");
   chk_trip_enters: assert property (trip |=> shutdown_active)
      else $error("enabled source did not shut down");
   chk_ac_high: assert property (held_down ##0 lvl[1:0] == level_high |-> pair_ac == 4'hf)
      else $error("ac pair not driven high");
   chk_bd_low: assert property (held_down ##0 lvl[3:2] == level_low |-> pair_bd == 4'h3)
      else $error("bd pair not driven low");
   chk_bd_float: assert property (held_down ##0 lvl[3:2] == level_float |-> pair_bd.enable == 2'h0)
      else $error("bd pair not released");
   chk_unmapped_err: assert property (psel && penable && paddr > off_irq_enable |-> pslverr)
      else $error("unmapped access not refused");
   chk_upper_zero: assert property (psel && penable && !pwrite
      && paddr == off_rising_deadband_count |-> prdata[31:6] == 26'h0)
      else $error("upper count bits not zero");
   chk_reset_clear: assert property (disable iff (1'b0) rst |=> !shutdown_active && !irq)
      else $error("reset left shutdown or irq");
endmodule
bind cwg_shutdown_deadband cwg_checker u_chk (.ref_clk(ref_clk), .rst(rst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .sources(sources), .pair_ac(pair_ac),
   .pair_bd(pair_bd), .shutdown_active(shutdown_active), .irq(irq));

// [tb/gate_driver_model.sv]
`timescale 1ns/1ps
// a released pin keeps showing the inverse of the last level driven on it
module gate_driver_model
   import cwg_pkg::*;
(
   // pairs from the generator
   input wire logic ref_clk,
   input wire pair_out_t pair_ac,
   input wire pair_out_t pair_bd,
   // pin levels a, c, b, d
   output logic [3:0] pins
);
   logic [3:0] drv_en;
   logic [3:0] drv_val;
   logic [3:0] last = 4'h0;
   assign drv_en = {pair_ac.enable, pair_bd.enable};
   assign drv_val = {pair_ac.value, pair_bd.value};
   always_ff @(posedge ref_clk)
   begin
      last <= (drv_val & drv_en) | (last & ~drv_en);
   end
   assign pins = (drv_val & drv_en) | (~last & ~drv_en);
endmodule

// [tb/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
   import cwg_pkg::*;
   logic ref_clk = 0, rst = 1, system_tick = 0, internal_fast_oscillator = 0;
   logic psel = 0, penable = 0, pwrite = 0, data_in = 0, pready, pslverr, sa, irq;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic [3:0] pins;
   logic [2:0] tc = 3'h0;
   logic e;
   logic [1:0] c;
   sources_t sources = 5'h00;
   pair_out_t pair_ac, pair_bd;
   int errors = 0, num_checks = 0;
   always #5 ref_clk = ~ref_clk;
   // generator ticks: every 2nd and every 3rd cycle
   always @(posedge ref_clk)
   begin
      tc <= (tc == 3'h5) ? 3'h0 : tc + 3'h1;
      system_tick <= tc[0];
      internal_fast_oscillator <= (tc == 3'h2 || tc == 3'h5);
   end
   cwg_shutdown_deadband u_dut (.ref_clk(ref_clk), .rst(rst), .system_tick(system_tick),
      .internal_fast_oscillator(internal_fast_oscillator), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .data_in(data_in), .sources(sources), .pair_ac(pair_ac),
      .pair_bd(pair_bd), .shutdown_active(sa), .irq(irq));
   gate_driver_model u_drv (.ref_clk(ref_clk), .pair_ac(pair_ac), .pair_bd(pair_bd),
      .pins(pins));
   task automatic cmp(input string n, input logic [31:0] x, input logic [31:0] g);
      num_checks++;
      if (g !== x)
      begin
         errors++;
         $display("BAD %s exp %h got %h", n, x, g);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      while (pready !== 1'b1)
         @(posedge ref_clk);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic rd(input string n, input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      cmp(n, x, r);
   endtask
   // shutdown level as {value, enable}; a released pair is compared on enable only
   task automatic lvl(input string n, input logic [1:0] k, input pair_out_t g);
      cmp(n, k == level_high ? 4'hf : k == level_low ? 4'h3 : k == level_float ? 4'h0 : 4'h7,
         k == level_float ? {2'h0, g.enable} : g);
   endtask
   // three cycles of pipeline plus n to n+1 generator periods of p cycles
   task automatic dly(input logic v, input int n, input int p);
      int k;
      int lo;
      int hi;
      k = 0;
      lo = (n == 0) ? 3 : n * p + 4;
      hi = (n == 0) ? 3 : n * p + p + 3;
      data_in <= v;
      @(posedge ref_clk);
      while (pair_ac.value[1] !== v && k < 400)
      begin
         k++;
         @(posedge ref_clk);
      end
      cmp("delay", 1, k >= lo && k <= hi);
      cmp("pair bd", {!v, v}, pair_bd.value);
      cmp("pins", {v, !v, !v, v}, pins);
   endtask
   task automatic stop_test();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      errors++;
      stop_test();
   end
   initial
   begin
      repeat (12) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      rd("src", off_shutdown_source_enable, 32'h0);
      rd("rise", off_rising_deadband_count, 32'h0);
      rd("fall", off_falling_deadband_count, 32'h0);
      apb(1'b1, off_shutdown_source_enable, 32'hffffffff);
      apb(1'b1, off_rising_deadband_count, 32'hffffffff);
      apb(1'b1, off_falling_deadband_count, 32'hffffffff);
      rd("src", off_shutdown_source_enable, 32'h1f);
      rd("rise", off_rising_deadband_count, 32'h3f);
      rd("fall", off_falling_deadband_count, 32'h3f);
      rd("unmapped", 8'h20, 32'h0);
      cmp("slverr", 1, e);
      for (int s = 0; s < 2; s++)
      begin
         apb(1'b1, off_waveform_clock_select, s);
         apb(1'b1, off_rising_deadband_count, 32'h0);
         apb(1'b1, off_falling_deadband_count, 32'h0);
         dly(1'b1, 0, 2 + s);
         dly(1'b0, 0, 2 + s);
         apb(1'b1, off_rising_deadband_count, 32'h2);
         apb(1'b1, off_falling_deadband_count, 32'h9);
         dly(1'b1, 2, 2 + s);
         dly(1'b0, 9, 2 + s);
      end
      apb(1'b1, off_rising_deadband_count, 32'h0);
      apb(1'b1, off_falling_deadband_count, 32'h0);
      for (int i = 0; i < 5; i++)
      begin
         c = i[1:0];
         apb(1'b1, off_shutdown_control, {26'h0, ~c, c, 2'h0});
         apb(1'b1, off_shutdown_source_enable, 32'h1 << i);
         sources <= ~(5'h1 << i);
         repeat (4) @(posedge ref_clk);
         cmp("masked", 0, sa);
         sources <= 5'h1f;
         repeat (4) @(posedge ref_clk);
         cmp("tripped", 1, sa);
         lvl("ac", c, pair_ac);
         lvl("bd", ~c, pair_bd);
         sources <= 5'h00;
         rd("ctl", off_shutdown_control, {24'h0, 2'h2, ~c, c, 2'h0});
         apb(1'b1, off_shutdown_control, {26'h0, ~c, c, 2'h0});
         cmp("cleared", 0, sa);
         lvl("hold", c, pair_ac);
      end
      dly(1'b1, 0, 3);
      rd("irq status", off_irq_status, 32'h1);
      cmp("irq masked", 0, irq);
      apb(1'b1, off_irq_enable, 32'h1);
      cmp("irq", 1, irq);
      apb(1'b1, off_irq_clear, 32'h1);
      cmp("irq cleared", 0, irq);
      rd("irq status", off_irq_status, 32'h0);
      rd("irq clear", off_irq_clear, 32'h0);
      apb(1'b1, off_shutdown_control, 32'h80);
      cmp("forced", 1, sa);
      apb(1'b1, off_shutdown_control, 32'hc0);
      rd("restart", off_shutdown_control, 32'h40);
      rd("irq both", off_irq_status, 32'h3);
      rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      cmp("reset sa", 0, sa);
      rd("src", off_shutdown_source_enable, 32'h0);
      rd("ctl", off_shutdown_control, 32'h0);
      rd("irq reset", off_irq_status, 32'h0);
      stop_test();
   end
endmodule
